/* inc/mspe_defs.vh */
// constants for the motion state program engine
`ifndef MSPE_DEFS_VH
`define MSPE_DEFS_VH
`define MSPE_ADDR_POS     8'h7C
`define MSPE_ADDR_TCL     8'h7D
`define MSPE_ADDR_TCH     8'h7E
`define MSPE_ADDR_OUT     8'h7F
`define MSPE_CMD_HALT     8'h00
`define MSPE_CMD_RESUME   8'h11
`define MSPE_CMD_BRANCH   8'h22
`define MSPE_CMD_MARK     8'h33
`define MSPE_C_NOP        4'h0
`define MSPE_C_T1         4'h1
`define MSPE_C_T2         4'h2
`define MSPE_C_T3         4'h3
`define MSPE_C_T4         4'h4
`define MSPE_C_GT1        4'h5
`define MSPE_C_GT2        4'h6
`define MSPE_C_LE1        4'h7
`define MSPE_C_LE2        4'h8
`define MSPE_C_GT1B       4'h9
`define MSPE_C_ALLLE2     4'hA
`define MSPE_C_GR1        4'hB
`define MSPE_C_LR1        4'hC
`define MSPE_C_GR2        4'hD
`define MSPE_C_LR2        4'hE
`define MSPE_C_ZC         4'hF
`define MSPE_PTR_START    4'h0
`define MSPE_BYTE_ZERO    8'h00
`define MSPE_TC_ZERO      16'h0000
`define MSPE_OUT_ZERO     8'h00
`endif

/* logic/mspe_engine.v */
// execution and readout logic of the second motion state program
`timescale 1ns/1ns
`include "mspe_defs.vh"

module mspe_engine #(
   parameter AW = 12
) (
   input  wire          ref_clk,
   input  wire          arst_n,
   input  wire          sample_valid,
   input  wire [AW-1:0] axis_x,
   input  wire [AW-1:0] axis_y,
   input  wire [AW-1:0] axis_z,
   input  wire [AW-1:0] axis_v,
   input  wire [AW-1:0] limit_one,
   input  wire [AW-1:0] limit_two,
   input  wire [7:0]    axis_mask,
   input  wire          timer_one_expired,
   input  wire          timer_two_expired,
   input  wire          timer_three_expired,
   input  wire          timer_four_expired,
   input  wire          output_on_halt_resume,
   input  wire          signed_limit_select,
   input  wire          copy_outputs_cmd,
   input  wire [7:0]    step_byte,
   input  wire          run_start,
   input  wire [15:0]   step_timer_load,
   input  wire          reg_rd,
   input  wire [7:0]    reg_addr,
   output reg  [7:0]    reg_rdata,
   output wire [3:0]    step_addr,
   output wire          running,
   output wire          int_release
);

   reg  [3:0]  program_pointer_r;
   reg  [3:0]  restart_point_r;
   reg  [15:0] step_timer_count_r;
   reg  [7:0]  output_flags_r;
   reg  [7:0]  output_flags_nxt;
   reg         run_r;
   reg  [1:0]  br_phase_r;      // 0 idle, 1 expect conditions, 2 expect addresses
   reg  [7:0]  br_cond_r;
   reg  [7:0]  br_addr_r;
   reg         br_active_r;
   reg  [3:0]  sign_prev_r;
   reg  [7:0]  trig_r;          // triggered direction, same layout as flags
   wire [AW-1:0] ax [0:3];
   reg  [7:0]  hit_gt1, hit_gt2, hit_le1, hit_le2, hit_gr1, hit_gr2, hit_zc;
   reg  [7:0]  dir;
   integer     i;

   // branch parameter phases
   localparam [1:0] BR_IDLE = 2'b00;
   localparam [1:0] BR_COND = 2'b01;
   localparam [1:0] BR_ADDR = 2'b10;

   assign ax[0] = axis_x;
   assign ax[1] = axis_y;
   assign ax[2] = axis_z;
   assign ax[3] = axis_v;
   assign step_addr = program_pointer_r;
   assign running   = run_r;

   // greater-than test, unsigned magnitude or signed by setting
   function cmp_gt;
      input [AW-1:0] a;
      input [AW-1:0] t;
      input          sgn;
      reg   [AW-1:0] mag;
      begin
         mag = a[AW-1] ? (~a + 1'b1) : a;
         if (sgn)
            cmp_gt = ($signed(a) > $signed(t));
         else
            cmp_gt = (mag > t);
      end
   endfunction

   // keeps the first set direction bit, msb first
   function [7:0] first_bit;
      input [7:0] v;
      integer     k;
      reg         found;
      begin
         first_bit = 8'h00;
         found = 1'b0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (v[k] && !found) begin
               first_bit[k] = 1'b1;
               found = 1'b1;
            end
         end
      end
   endfunction

   // per-axis comparison vectors, two bits per axis: positive then negative
   always @* begin
      hit_gt1 = 8'h00;
      hit_gt2 = 8'h00;
      hit_le1 = 8'h00;
      hit_le2 = 8'h00;
      hit_gr1 = 8'h00;
      hit_gr2 = 8'h00;
      hit_zc  = 8'h00;
      dir     = 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
         dir[7-2*i] = ~ax[i][AW-1];
         dir[6-2*i] = ax[i][AW-1];
         if (cmp_gt(ax[i], limit_one, signed_limit_select)) begin
            hit_gt1[7-2*i] = ~ax[i][AW-1];
            hit_gt1[6-2*i] = ax[i][AW-1];
         end
         if (cmp_gt(ax[i], limit_two, signed_limit_select)) begin
            hit_gt2[7-2*i] = ~ax[i][AW-1];
            hit_gt2[6-2*i] = ax[i][AW-1];
         end
         if (cmp_gt(ax[i], ~limit_one + 1'b1, signed_limit_select)) begin
            hit_gr1[7-2*i] = ~ax[i][AW-1];
            hit_gr1[6-2*i] = ax[i][AW-1];
         end
         if (cmp_gt(ax[i], ~limit_two + 1'b1, signed_limit_select)) begin
            hit_gr2[7-2*i] = ~ax[i][AW-1];
            hit_gr2[6-2*i] = ax[i][AW-1];
         end
         if (sign_prev_r[i] != ax[i][AW-1]) begin
            hit_zc[7-2*i] = 1'b1;
            hit_zc[6-2*i] = 1'b1;
         end
      end
      hit_le1 = dir & ~hit_gt1;
      hit_le2 = dir & ~hit_gt2;
   end

   // evaluates one condition code, returning the triggering direction set;
   // everything it reads is an argument, so callers update when any of it moves
   function [7:0] eval;
      input [3:0] code;
      input [7:0] m;
      input       t1;
      input       t2;
      input       t3;
      input       t4;
      input [7:0] gt1;
      input [7:0] gt2;
      input [7:0] le1;
      input [7:0] le2;
      input [7:0] gr1;
      input [7:0] gr2;
      input [7:0] zc;
      input [7:0] dv;
      begin
         case (code)
            `MSPE_C_NOP:    eval = 8'h00;
            `MSPE_C_T1:     eval = {8{t1}};
            `MSPE_C_T2:     eval = {8{t2}};
            `MSPE_C_T3:     eval = {8{t3}};
            `MSPE_C_T4:     eval = {8{t4}};
            `MSPE_C_GT1,
            `MSPE_C_GT1B:   eval = gt1 & m;
            `MSPE_C_GT2:    eval = gt2 & m;
            `MSPE_C_LE1:    eval = le1 & m;
            `MSPE_C_LE2:    eval = le2 & m;
            `MSPE_C_ALLLE2: eval = (((le2 | ~dv) & m) == m && m != 8'h00) ?
                                   first_bit(m) : 8'h00;
            `MSPE_C_GR1:    eval = gr1 & m;
            `MSPE_C_LR1:    eval = dv & ~gr1 & m;
            `MSPE_C_GR2:    eval = gr2 & m;
            `MSPE_C_LR2:    eval = dv & ~gr2 & m;
            `MSPE_C_ZC:     eval = zc & m;
            default:        eval = 8'h00;
         endcase
      end
   endfunction

   wire       is_cmd  = (step_byte[7:4] == step_byte[3:0]);
   wire [7:0] msk     = (trig_r != 8'h00) ? trig_r : axis_mask;
   wire [7:0] r_hit   = eval(step_byte[7:4], msk, timer_one_expired, timer_two_expired,
                             timer_three_expired, timer_four_expired, hit_gt1, hit_gt2,
                             hit_le1, hit_le2, hit_gr1, hit_gr2, hit_zc, dir);
   wire [7:0] n_hit   = eval(step_byte[3:0], msk, timer_one_expired, timer_two_expired,
                             timer_three_expired, timer_four_expired, hit_gt1, hit_gt2,
                             hit_le1, hit_le2, hit_gr1, hit_gr2, hit_zc, dir);
   wire [7:0] b0_hit  = eval(br_cond_r[3:0], msk, timer_one_expired, timer_two_expired,
                             timer_three_expired, timer_four_expired, hit_gt1, hit_gt2,
                             hit_le1, hit_le2, hit_gr1, hit_gr2, hit_zc, dir);
   wire [7:0] b1_hit  = eval(br_cond_r[7:4], msk, timer_one_expired, timer_two_expired,
                             timer_three_expired, timer_four_expired, hit_gt1, hit_gt2,
                             hit_le1, hit_le2, hit_gr1, hit_gr2, hit_zc, dir);
   wire       n_true  = (step_byte[3:0] == `MSPE_C_NOP) | (n_hit != 8'h00);
   wire       rd_out  = reg_rd && (reg_addr == `MSPE_ADDR_OUT);
   wire [3:0] pp_inc  = program_pointer_r + 4'h1;

   assign int_release = rd_out;

   // read mux of the readout registers
   always @* begin
      case (reg_addr)
         `MSPE_ADDR_POS: reg_rdata = {restart_point_r, program_pointer_r};
         `MSPE_ADDR_TCL: reg_rdata = step_timer_count_r[7:0];
         `MSPE_ADDR_TCH: reg_rdata = step_timer_count_r[15:8];
         `MSPE_ADDR_OUT: reg_rdata = output_flags_r;
         default:        reg_rdata = `MSPE_BYTE_ZERO;
      endcase
   end

   // output flag next value: copy wins over read clear
   always @* begin
      output_flags_nxt = output_flags_r;
      if (rd_out)
         output_flags_nxt = `MSPE_OUT_ZERO;
      if (copy_outputs_cmd ||
          (run_r && output_on_halt_resume && is_cmd && br_phase_r == BR_IDLE &&
           (step_byte == `MSPE_CMD_HALT || step_byte == `MSPE_CMD_RESUME)))
         output_flags_nxt = output_flags_r | trig_r;
   end

   // program flow
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         program_pointer_r  <= `MSPE_PTR_START;
         restart_point_r    <= `MSPE_PTR_START;
         step_timer_count_r <= `MSPE_TC_ZERO;
         output_flags_r     <= `MSPE_OUT_ZERO;
         run_r              <= 1'b0;
         br_phase_r         <= BR_IDLE;
         br_cond_r          <= `MSPE_BYTE_ZERO;
         br_addr_r          <= `MSPE_BYTE_ZERO;
         br_active_r        <= 1'b0;
         sign_prev_r        <= 4'h0;
         trig_r             <= `MSPE_BYTE_ZERO;
      end else begin
         output_flags_r <= output_flags_nxt;
         if (step_timer_count_r != `MSPE_TC_ZERO)
            step_timer_count_r <= step_timer_count_r - 16'h0001;
         if (sample_valid)
            sign_prev_r <= {axis_v[AW-1], axis_z[AW-1], axis_y[AW-1], axis_x[AW-1]};
         if (!run_r) begin
            if (run_start) begin
               run_r <= 1'b1;
               program_pointer_r <= restart_point_r;
            end
         end else if (br_phase_r == BR_COND) begin
            br_cond_r <= step_byte;
            br_phase_r <= BR_ADDR;
            program_pointer_r <= pp_inc;
         end else if (br_phase_r == BR_ADDR) begin
            br_addr_r <= step_byte;
            br_phase_r <= BR_IDLE;
            br_active_r <= 1'b1;
            program_pointer_r <= pp_inc;
         end else if (is_cmd) begin
            case (step_byte)
               `MSPE_CMD_HALT: begin
                  run_r <= 1'b0;
                  restart_point_r <= `MSPE_PTR_START;
                  program_pointer_r <= `MSPE_PTR_START;
               end
               `MSPE_CMD_RESUME: begin
                  program_pointer_r <= restart_point_r;
               end
               `MSPE_CMD_BRANCH: begin
                  br_phase_r <= BR_COND;
                  program_pointer_r <= pp_inc;
               end
               `MSPE_CMD_MARK: begin
                  restart_point_r <= pp_inc;
                  program_pointer_r <= pp_inc;
               end
               default: begin
                  program_pointer_r <= pp_inc;
               end
            endcase
         end else if (sample_valid) begin
            if (br_active_r && b0_hit != 8'h00) begin
               program_pointer_r <= br_addr_r[3:0];
               trig_r <= first_bit(b0_hit);
               br_active_r <= 1'b0;
            end else if (br_active_r && b1_hit != 8'h00) begin
               program_pointer_r <= br_addr_r[7:4];
               trig_r <= first_bit(b1_hit);
               br_active_r <= 1'b0;
            end else if (step_byte[7:4] != `MSPE_C_NOP && r_hit != 8'h00) begin
               program_pointer_r <= restart_point_r;
               trig_r <= `MSPE_BYTE_ZERO;
               step_timer_count_r <= step_timer_load;
            end else if (n_true) begin
               program_pointer_r <= pp_inc;
               step_timer_count_r <= step_timer_load;
               if (n_hit != 8'h00 && step_byte[3:0] > `MSPE_C_T4)
                  trig_r <= first_bit(n_hit);
            end
         end
      end
   end

endmodule

/* dv/mspe_prog_mem.sv */
// program store model that hands step bytes to the engine
`timescale 1ns/1ns
module mspe_prog_mem (
   input  logic       ref_clk,
   input  logic       wr_en,
   input  logic [3:0] wr_addr,
   input  logic [7:0] wr_data,
   input  logic [3:0] step_addr,
   output logic [7:0] step_byte
);
   logic [7:0] mem_r [0:15];
   // host loads the program steps
   always @(posedge ref_clk) begin
      if (wr_en) mem_r[wr_addr] <= wr_data;
   end
   // combinational fetch at the program pointer
   assign step_byte = mem_r[step_addr];
endmodule

/* dv/mspe_engine_chk.sv */
// port checker for the motion state program engine
`timescale 1ns/1ns
module mspe_engine_chk (
   input logic       ref_clk,
   input logic       arst_n,
   input logic       sample_valid,
   input logic       timer_one_expired,
   input logic       timer_two_expired,
   input logic       output_on_halt_resume,
   input logic       copy_outputs_cmd,
   input logic [7:0] step_byte,
   input logic       run_start,
   input logic       reg_rd,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_rdata,
   input logic [3:0] step_addr,
   input logic       running,
   input logic       int_release
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // register readout and release pulse
   release_pulse_a : assert property (int_release == (reg_rd && reg_addr == 8'h7F))
      else $error("release pulse does not follow flag read");
   read_clear_a : assert property ((reg_rd && reg_addr == 8'h7F && !copy_outputs_cmd
      && !output_on_halt_resume) |=> (reg_addr != 8'h7F || reg_rdata == 8'h00))
      else $error("flags not cleared by read");
   unmapped_zero_a : assert property ((reg_addr < 8'h7C) |-> reg_rdata == 8'h00)
      else $error("unmapped address reads nonzero");
   pointer_nibble_a : assert property ((reg_addr == 8'h7C) |-> reg_rdata[3:0] == step_addr)
      else $error("position low nibble differs from pointer");
   // program flow
   halt_cmd_a : assert property ((running && step_byte == 8'h00)
      |=> (!running && step_addr == 4'h0))
      else $error("halt did not stop and rewind");
   mark_cmd_a : assert property ((running && step_byte == 8'h33) ##1 (reg_addr == 8'h7C)
      |-> reg_rdata[7:4] == $past(step_addr) + 4'h1)
      else $error("restart point not next step");
   idle_hold_a : assert property ((!running && !run_start) |=> $stable(step_addr))
      else $error("pointer moved while halted");
   nop_advance_a : assert property ((running && sample_valid && step_byte == 8'h10
      && !timer_one_expired) |=> step_addr == $past(step_addr) + 4'h1)
      else $error("no-operation condition did not advance");
   timer_next_a : assert property ((running && sample_valid && step_byte == 8'h21
      && timer_one_expired && !timer_two_expired) |=> step_addr == $past(step_addr) + 4'h1)
      else $error("timer condition did not advance");
   timer_wait_a : assert property ((running && sample_valid && step_byte == 8'h21
      && !timer_one_expired && !timer_two_expired) |=> $stable(step_addr))
      else $error("pointer moved without timer expiry");
endmodule
bind mspe_engine mspe_engine_chk chk_u (.*);

/* dv/tb_motion_state_program_engine.sv */
// self-checking bench for the motion state program engine
`timescale 1ns/1ns
module tb_motion_state_program_engine;
   logic        ref_clk, arst_n, sample_valid, reg_rd, run_start, copy_outputs_cmd, wr_en;
   logic        timer_one_expired, timer_two_expired, timer_three_expired, timer_four_expired;
   logic        output_on_halt_resume, signed_limit_select, running, int_release;
   logic [11:0] axis_x, axis_y, axis_z, axis_v, limit_one, limit_two;
   logic [7:0]  axis_mask, step_byte, reg_addr, reg_rdata, wr_data;
   logic [15:0] step_timer_load;
   logic [3:0]  step_addr, wr_addr;
   int          err_count, checks_done;
   // program images, step 0 in the top byte
   localparam logic [127:0] PROG_A = 128'h33052110_00000000_00000000_00000000;
   localparam logic [127:0] PROG_B = 128'h3322F196_20000000_00110000_00000000;

   mspe_engine dut_u (.*);
   mspe_prog_mem mem_u (.*);

   // free running clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task cyc;
      @(posedge ref_clk);
      #2;
   endtask

   task tally_and_finish;
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one register read, checked before the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      cyc;
      reg_rd = 1'b1;
      reg_addr = a;
      #10;
      checks_done++;
      if (reg_rdata !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, reg_rdata);
         err_count++;
      end
      checks_done++;
      if (int_release !== (a == 8'h7F)) begin
         $display("BAD int_release expected %0b seen %0b", a == 8'h7F, int_release);
         err_count++;
      end
      cyc;
      reg_rd = 1'b0;
   endtask

   // one cycle sample strobe
   task smp;
      cyc;
      sample_valid = 1'b1;
      cyc;
      sample_valid = 1'b0;
   endtask

   // bounded wait for the run state
   task automatic wait_run(input logic lvl);
      int n;
      n = 0;
      while (running !== lvl && n < 50) begin
         cyc;
         n++;
      end
      if (running !== lvl) begin
         $display("BAD running expected %0b seen %0b", lvl, running);
         err_count++;
         tally_and_finish;
      end
   endtask

   // loads a program image and starts it from the restart point
   task automatic load_and_run(input logic [127:0] img);
      for (int i = 0; i < 16; i++) begin
         cyc;
         wr_en = 1'b1;
         wr_addr = i[3:0];
         wr_data = img[8*(15-i) +: 8];
      end
      cyc;
      wr_en = 1'b0;
      reg_addr = 8'h7C;
      run_start = 1'b1;
      cyc;
      run_start = 1'b0;
      wait_run(1'b1);
   endtask

   // main sequence
   initial begin
      {sample_valid, reg_rd, run_start, copy_outputs_cmd, wr_en} = 5'h00;
      {timer_one_expired, timer_two_expired, timer_three_expired, timer_four_expired} = 4'h0;
      {output_on_halt_resume, signed_limit_select} = 2'h0;
      {axis_x, axis_y, axis_z, axis_v} = 48'h0;
      limit_one = 12'h032;
      limit_two = 12'h064;
      axis_mask = 8'hFF;
      reg_addr = 8'h00;
      wr_addr = 4'h0;
      wr_data = 8'h00;
      step_timer_load = 16'h0040;
      err_count = 0;
      checks_done = 0;
      arst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      #2 arst_n = 1'b1;
      rd(8'h7C, 8'h00, "position");
      rd(8'h7D, 8'h00, "timer_low");
      rd(8'h7E, 8'h00, "timer_high");
      rd(8'h7F, 8'h00, "flags");
      rd(8'h10, 8'h00, "unmapped");
      load_and_run(PROG_A);
      repeat (3) cyc;
      rd(8'h7C, 8'h11, "position");
      axis_x = 12'h064;
      smp;
      rd(8'h7D, 8'h3F, "timer_low");
      rd(8'h7C, 8'h12, "position");
      cyc;
      copy_outputs_cmd = 1'b1;
      cyc;
      copy_outputs_cmd = 1'b0;
      rd(8'h7F, 8'h80, "flags");
      rd(8'h7F, 8'h00, "flags");
      smp;
      rd(8'h7C, 8'h12, "position");
      timer_one_expired = 1'b1;
      smp;
      rd(8'h7C, 8'h13, "position");
      timer_one_expired = 1'b0;
      smp;
      wait_run(1'b0);
      rd(8'h7C, 8'h00, "position");
      // second program: branch on a zero crossing into a resume that copies outputs
      output_on_halt_resume = 1'b1;
      load_and_run(PROG_B);
      repeat (4) cyc;
      rd(8'h7C, 8'h14, "position");
      axis_x = 12'hF9C;
      smp;
      repeat (3) cyc;
      rd(8'h7F, 8'h80, "flags");
      rd(8'h7C, 8'h14, "position");
      tally_and_finish;
   end
endmodule
